// *** rtl/lcd_params.svh ***
`ifndef LCD_SEGMENT_PARAMS_SVH
`define LCD_SEGMENT_PARAMS_SVH
// register addresses
`define DISP_CTRL_ADDR 7'h2C
`define DUTY_CLK_ADDR 7'h2D
`define RAM_FIRST_ADDR 7'h50
`define RAM_LAST_ADDR 7'h6F
`define RAM_LAST_REDUCED 7'h67
// display control field positions
`define BIT_DISPLAY_ON 2'h0
`define BIT_POWER_SW 2'h1
`define BIT_LP_DISPLAY 2'h2
`define BIT_DIVIDER 2'h3
`define CTRL_RESET 4'h0
`define DUTY_CLK_RESET 4'h0
// duty/clock field positions
`define DUTY_LSB 0
`define DUTY_MSB 1
`define CLKSEL_LSB 2
`define CLKSEL_MSB 3
// segment and common counts
`define SEG_COUNT 32
`define SEG_COUNT_REDUCED 24
`define COM_COUNT 4
// source ticks per common phase
`define CL0_TICKS 12'h080
`define CL1_TICKS 12'h100
`define CL2_TICKS 12'h100
`define CL3_PER_TICKS 12'h800
`define CL3_SUB_TICKS 12'h200
// last phase index for each duty
`define LAST_PHASE_QUARTER 2'h3
`define LAST_PHASE_THIRD 2'h2
`define LAST_PHASE_HALF 2'h1
`define LAST_PHASE_STATIC 2'h0
`endif

// *** rtl/lcd_pkg.sv ***
package lcd_pkg;
  typedef enum logic [1:0] {
    DUTY_QUARTER,
    DUTY_THIRD,
    DUTY_HALF,
    DUTY_STATIC
  } duty_type;

  typedef enum logic [1:0] {
    CLK_SUB_FAST,
    CLK_SUB_SLOW,
    CLK_PER_FAST,
    CLK_PER_SLOW
  } clk_src_type;

  // one processor access per cycle
  typedef struct packed {
    logic wr;
    logic rd;
    logic bit_set;
    logic bit_clear;
    logic [1:0] bit_index;
    logic [6:0] addr;
    logic [3:0] data;
  } cpu_req_type;
endpackage : lcd_pkg

// *** rtl/display_ram.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "lcd_params.svh"
module display_ram (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic wr_en,
  input wire logic [4:0] wr_index,
  input wire logic [3:0] wr_data,
  input wire logic [4:0] rd_index,
  output logic [3:0] rd_word,
  output logic [4*`SEG_COUNT-1:0] scan_words
);
  logic [3:0] mem [`SEG_COUNT];

  // ------------------------------------------------------------
  // storage
  // ------------------------------------------------------------
  // processor port writes; cleared at reset so nothing random shows
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < `SEG_COUNT; i++) begin
        mem[i] <= 4'h0;
      end
    end else if (ce && wr_en) begin
      mem[wr_index] <= wr_data;
    end
  end

  // ------------------------------------------------------------
  // read ports
  // ------------------------------------------------------------
  // scan side sees every word at once, no arbitration with the cpu
  always_comb begin
    rd_word = mem[rd_index];
    for (int i = 0; i < `SEG_COUNT; i++) begin
      scan_words[4*i +: 4] = mem[i];
    end
  end
endmodule : display_ram
`default_nettype wire

// *** rtl/frame_timer.sv ***
`timescale 1ns/1ps
`default_nettype none
module frame_timer (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic src_tick,
  input wire logic [11:0] period,
  input wire logic restart,
  output logic step
);
  logic [11:0] count_reg;

  // ------------------------------------------------------------
  // phase divider
  // ------------------------------------------------------------
  // counts source ticks; restart realigns after a clock change
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      count_reg <= 12'h000;
      step <= 1'b0;
    end else if (ce) begin
      step <= 1'b0;
      if (restart) begin
        count_reg <= 12'h000;
      end else if (src_tick) begin
        if (count_reg >= period - 12'h001) begin
          count_reg <= 12'h000;
          step <= 1'b1;
        end else begin
          count_reg <= count_reg + 12'h001;
        end
      end
    end
  end
endmodule : frame_timer
`default_nettype wire

// *** rtl/lcd_segment_controller.sv ***
// How it works
// RULE1: four commons, 32 segments, 24 when reduced
// RULE2: dual-port memory scanned without processor help
// RULE3: software picks duty and reference clock
// RULE4: sub-clock source keeps display alive in watch
// RULE5: display words at 050h..06Fh, 067h reduced
// RULE6: bit3..bit0 map to fourth..first common
// RULE7: write-only 4-bit control at 02Ch
// RULE8: single control bits set or cleared alone
// RULE9: display off forces segments unlit
// RULE10: power switch bit opens/closes switch
// RULE11: low-power display off grounds all pins
// RULE12: low-power display on keeps segments driven
// RULE13: divider bit connects supply divider resistor
// RULE14: duty field 00 quarter..11 static
// RULE15: control fields positioned by constants, reset off
`timescale 1ns/1ps
`default_nettype none
`include "lcd_params.svh"
module lcd_segment_controller #(
  parameter bit REDUCED_VARIANT = 1'b0
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic ce,
  input wire lcd_pkg::cpu_req_type cpu_req,
  output logic [3:0] rd_data_reg,
  input wire logic sub_tick,
  input wire logic per_tick,
  input wire logic timer_a_sub_select,
  input wire logic low_power_mode,
  output logic [`COM_COUNT-1:0] common_out_reg,
  output logic [`SEG_COUNT-1:0] segment_out_reg,
  output logic drive_active_reg,
  output logic power_switch_reg,
  output logic divider_connect_reg
);
  // ------------------------------------------------------------
  // declarations
  // ------------------------------------------------------------
  logic [3:0] display_control_reg;
  logic [3:0] duty_clock_select_reg;
  logic [1:0] phase_reg;
  logic invert_reg;
  logic [1:0] last_phase;
  logic [11:0] period;
  logic src_tick;
  logic step;
  logic restart;
  logic ram_hit;
  logic [6:0] ram_last;
  logic [6:0] ram_offset;
  logic [4:0] ram_index;
  logic [3:0] ram_word;
  logic [4*`SEG_COUNT-1:0] scan_words;
  logic ground_all;
  logic display_on;
  logic [`SEG_COUNT-1:0] segment_next;
  logic [`COM_COUNT-1:0] common_next;
  logic [3:0] ctrl_next;
  logic [3:0] duty_next;
  lcd_pkg::duty_type duty;
  lcd_pkg::clk_src_type clk_src;

  // ------------------------------------------------------------
  // address decode
  // ------------------------------------------------------------
  // reduced part simply has a shorter display window
  assign ram_last = REDUCED_VARIANT ? `RAM_LAST_REDUCED : `RAM_LAST_ADDR;
  assign ram_offset = cpu_req.addr - `RAM_FIRST_ADDR;
  assign ram_index = ram_offset[4:0];

  always_comb begin
    if (cpu_req.addr >= `RAM_FIRST_ADDR && cpu_req.addr <= ram_last) begin
      ram_hit = 1'b1; // see RULE5
    end else begin
      ram_hit = 1'b0;
    end
  end

  // ------------------------------------------------------------
  // write-only control registers
  // ------------------------------------------------------------
  // plain write, or one bit set/cleared leaving the rest alone
  always_comb begin
    ctrl_next = display_control_reg;
    if (cpu_req.addr == `DISP_CTRL_ADDR) begin
      if (cpu_req.wr) begin
        ctrl_next = cpu_req.data; // see RULE7
      end else if (cpu_req.bit_set) begin
        ctrl_next[cpu_req.bit_index] = 1'b1; // see RULE8
      end else if (cpu_req.bit_clear) begin
        ctrl_next[cpu_req.bit_index] = 1'b0; // see RULE8
      end
    end
  end

  always_comb begin
    duty_next = duty_clock_select_reg;
    if (cpu_req.addr == `DUTY_CLK_ADDR) begin
      if (cpu_req.wr) begin
        duty_next = cpu_req.data; // see RULE3
      end else if (cpu_req.bit_set) begin
        duty_next[cpu_req.bit_index] = 1'b1;
      end else if (cpu_req.bit_clear) begin
        duty_next[cpu_req.bit_index] = 1'b0;
      end
    end
  end

  // all controls start off: display blank, switch open, resistor out
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      display_control_reg <= `CTRL_RESET; // see RULE15
    end else if (ce) begin
      display_control_reg <= ctrl_next;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      duty_clock_select_reg <= `DUTY_CLK_RESET;
    end else if (ce) begin
      duty_clock_select_reg <= duty_next;
    end
  end

  // ------------------------------------------------------------
  // processor read port
  // ------------------------------------------------------------
  // control registers are write-only and read back as zero
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data_reg <= 4'h0;
    end else if (ce) begin
      if (cpu_req.rd && ram_hit) begin
        rd_data_reg <= ram_word;
      end else if (cpu_req.rd) begin
        rd_data_reg <= 4'h0;
      end
    end
  end

  // ------------------------------------------------------------
  // display memory
  // ------------------------------------------------------------
  display_ram u_ram (
    .mclk(mclk),
    .rst_n(rst_n),
    .ce(ce),
    .wr_en(cpu_req.wr && ram_hit),
    .wr_index(ram_index),
    .wr_data(cpu_req.data),
    .rd_index(ram_index),
    .rd_word(ram_word),
    .scan_words(scan_words) // see RULE2
  );

  // ------------------------------------------------------------
  // reference clock and duty
  // ------------------------------------------------------------
  assign duty = lcd_pkg::duty_type'(duty_clock_select_reg[`DUTY_MSB:`DUTY_LSB]);
  assign clk_src = lcd_pkg::clk_src_type'(duty_clock_select_reg[`CLKSEL_MSB:`CLKSEL_LSB]);

  // system-derived ticks vanish in low power since the main clock
  // stops there; only the sub-clock keeps the scan going
  always_comb begin
    src_tick = sub_tick;
    period = `CL0_TICKS;
    case (clk_src)
      lcd_pkg::CLK_SUB_FAST: begin
        src_tick = sub_tick; // see RULE4
        period = `CL0_TICKS;
      end
      lcd_pkg::CLK_SUB_SLOW: begin
        src_tick = sub_tick; // see RULE4
        period = `CL1_TICKS;
      end
      lcd_pkg::CLK_PER_FAST: begin
        src_tick = per_tick && !low_power_mode;
        period = `CL2_TICKS;
      end
      default: begin
        if (timer_a_sub_select) begin
          src_tick = sub_tick;
          period = `CL3_SUB_TICKS;
        end else begin
          src_tick = per_tick && !low_power_mode;
          period = `CL3_PER_TICKS;
        end
      end
    endcase
  end

  // last common phase index per frame
  always_comb begin
    case (duty)
      lcd_pkg::DUTY_QUARTER: last_phase = `LAST_PHASE_QUARTER; // see RULE14
      lcd_pkg::DUTY_THIRD: last_phase = `LAST_PHASE_THIRD; // see RULE14
      lcd_pkg::DUTY_HALF: last_phase = `LAST_PHASE_HALF; // see RULE14
      default: last_phase = `LAST_PHASE_STATIC; // see RULE14
    endcase
  end

  // a change of clock setting restarts the divider cleanly
  assign restart = (duty_next != duty_clock_select_reg);

  frame_timer u_timer (
    .mclk(mclk),
    .rst_n(rst_n),
    .ce(ce),
    .src_tick(src_tick),
    .period(period),
    .restart(restart),
    .step(step)
  );

  // ------------------------------------------------------------
  // common phase sequencer
  // ------------------------------------------------------------
  // polarity flips each frame so the panel sees no dc component
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      phase_reg <= 2'h0;
      invert_reg <= 1'b0;
    end else if (ce) begin
      if (phase_reg > last_phase) begin
        phase_reg <= 2'h0; // duty shrank mid-frame
      end else if (step) begin
        if (phase_reg == last_phase) begin
          phase_reg <= 2'h0;
          invert_reg <= !invert_reg;
        end else begin
          phase_reg <= phase_reg + 2'h1;
        end
      end
    end
  end

  // ------------------------------------------------------------
  // drive levels
  // ------------------------------------------------------------
  assign ground_all = low_power_mode && !display_control_reg[`BIT_LP_DISPLAY]; // see RULE11
  assign display_on = display_control_reg[`BIT_DISPLAY_ON];

  // selected common is the opposite of frame polarity; unused ones
  // beyond the duty just sit at the non-selected level
  always_comb begin
    common_next = {`COM_COUNT{invert_reg}};
    common_next[phase_reg] = !invert_reg; // see RULE1
    if (ground_all) begin
      common_next = '0; // see RULE11
    end
  end

  // segment lit when its bit for the active common is set
  always_comb begin
    segment_next = '0;
    for (int i = 0; i < `SEG_COUNT; i++) begin
      if (ground_all) begin
        segment_next[i] = 1'b0; // see RULE11
      end else if (REDUCED_VARIANT && i >= `SEG_COUNT_REDUCED) begin
        segment_next[i] = invert_reg; // see RULE1
      end else if (!display_on) begin
        segment_next[i] = invert_reg; // see RULE9
      end else begin
        // see RULE6
        segment_next[i] = scan_words[4*i + 32'(phase_reg)] ^ invert_reg; // see RULE12
      end
    end
  end

  // every panel output leaves straight from a flip-flop
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      common_out_reg <= '0;
      segment_out_reg <= '0;
      drive_active_reg <= 1'b0;
    end else if (ce) begin
      common_out_reg <= common_next;
      segment_out_reg <= segment_next;
      drive_active_reg <= !ground_all;
    end
  end

  // ------------------------------------------------------------
  // supply controls
  // ------------------------------------------------------------
  // switch forced open while pins are grounded to save current
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      power_switch_reg <= 1'b0;
      divider_connect_reg <= 1'b0;
    end else if (ce) begin
      power_switch_reg <= display_control_reg[`BIT_POWER_SW] && !ground_all; // see RULE10
      divider_connect_reg <= display_control_reg[`BIT_DIVIDER]; // see RULE13
    end
  end
endmodule : lcd_segment_controller
`default_nettype wire

// *** verification/lcd_props.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "lcd_params.svh"
// ----------------------------------------
// port-level checks of the display block
// ----------------------------------------
module lcd_props #(
  parameter bit REDUCED_VARIANT = 1'b0
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic ce,
  input wire lcd_pkg::cpu_req_type cpu_req,
  input wire logic low_power_mode,
  input wire logic [3:0] rd_data_reg,
  input wire logic [`COM_COUNT-1:0] common_out_reg,
  input wire logic [`SEG_COUNT-1:0] segment_out_reg,
  input wire logic drive_active_reg,
  input wire logic power_switch_reg,
  input wire logic divider_connect_reg
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // decoded requests; a write outranks a read in the same cycle
  wire logic [6:0] a = cpu_req.addr;
  wire logic rd = ce && cpu_req.rd && !cpu_req.wr;
  wire logic ctl_wr = ce && cpu_req.wr && a == `DISP_CTRL_ADDR;
  wire logic [6:0] top = REDUCED_VARIANT ? `RAM_LAST_REDUCED : `RAM_LAST_ADDR;
  wire logic in_ram = a >= `RAM_FIRST_ADDR && a <= top;
  wire logic div_op = ce && (cpu_req.bit_set || cpu_req.bit_clear) && !cpu_req.wr;

  AST_RD_ZERO: assert property (rd && !in_ram |=> rd_data_reg == 4'h0)
    else $error("read outside display memory not zero");
  AST_RD_HOLD: assert property (!(ce && cpu_req.rd) |=> $stable(rd_data_reg))
    else $error("read data moved without a read");
  AST_RAM_BACK: assert property (ce && cpu_req.wr && in_ram ##1 rd && a == $past(a)
    |=> rd_data_reg == $past(cpu_req.data, 2))
    else $error("display word read back wrong");
  AST_GROUND: assert property (!drive_active_reg |-> common_out_reg == '0
    && segment_out_reg == '0 && !power_switch_reg)
    else $error("grounded state not clean");
  AST_COM_SHAPE: assert property (drive_active_reg
    |-> $onehot(common_out_reg) || $onehot(~common_out_reg))
    else $error("commons do not select exactly one");
  AST_DIVIDER: assert property (ctl_wr |-> ##2
    divider_connect_reg == $past(cpu_req.data[3], 2))
    else $error("divider does not follow control write");
  AST_PSW: assert property (ctl_wr && !low_power_mode ##1 !low_power_mode[*2]
    |-> power_switch_reg == $past(cpu_req.data[1], 2))
    else $error("power switch does not follow control write");
  AST_BIT_OP: assert property (div_op && a == `DISP_CTRL_ADDR && cpu_req.bit_index == `BIT_DIVIDER
    |-> ##2 divider_connect_reg == $past(cpu_req.bit_set, 2))
    else $error("single bit operation missed divider");
endmodule : lcd_props

bind lcd_segment_controller lcd_props #(.REDUCED_VARIANT(REDUCED_VARIANT)) lcd_props_i (
  .mclk(mclk), .rst_n(rst_n), .ce(ce), .cpu_req(cpu_req), .low_power_mode(low_power_mode),
  .rd_data_reg(rd_data_reg), .common_out_reg(common_out_reg),
  .segment_out_reg(segment_out_reg), .drive_active_reg(drive_active_reg),
  .power_switch_reg(power_switch_reg), .divider_connect_reg(divider_connect_reg));
`default_nettype wire

// *** verification/lcd_panel.sv ***
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// multiplexed panel: which pixels are lit
// ----------------------------------------
module lcd_panel (
  input wire logic [3:0] common_out_reg,
  input wire logic [31:0] segment_out_reg,
  output logic [1:0] sel_com,
  output logic [31:0] lit
);
  // selected common differs from the others; equal commons mean no drive at all
  always_comb begin
    sel_com = 2'h0;
    for (int i = 0; i < 4; i++) begin
      if (common_out_reg[i] != common_out_reg[i ^ 1] && common_out_reg[i] != common_out_reg[i ^ 2]) begin
        sel_com = 2'(i);
      end
    end
    lit = segment_out_reg ~^ {32{common_out_reg[sel_com]}};
    if (&common_out_reg || ~|common_out_reg) begin
      lit = 32'h0;
    end
  end
endmodule : lcd_panel
`default_nettype wire

// *** verification/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "lcd_params.svh"
module tb_top;
  // ----------------------------------------
  // bench signals and instances
  // ----------------------------------------
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic low_power_mode = 1'b0;
  logic ce = 1'b1;
  logic timer_a_sub_select = 1'b1;
  logic [3:0] held_com;
  lcd_pkg::cpu_req_type cpu_req = '0;
  logic [3:0] rd_data_reg;
  logic [3:0] common_out_reg;
  logic [31:0] segment_out_reg;
  logic drive_active_reg;
  logic power_switch_reg;
  logic divider_connect_reg;
  logic [1:0] sel_com;
  logic [31:0] lit;
  logic [3:0] mem [32];
  int n_errors = 0;
  int tests_run = 0;

  always #12.5 mclk = ~mclk;

  // sub ticks every cycle keep frame periods short
  lcd_segment_controller lcd_segment_controller_i (.mclk(mclk), .rst_n(rst_n), .ce(ce),
    .cpu_req(cpu_req), .rd_data_reg(rd_data_reg), .sub_tick(1'b1), .per_tick(1'b1),
    .timer_a_sub_select(timer_a_sub_select), .low_power_mode(low_power_mode),
    .common_out_reg(common_out_reg), .segment_out_reg(segment_out_reg),
    .drive_active_reg(drive_active_reg), .power_switch_reg(power_switch_reg),
    .divider_connect_reg(divider_connect_reg));
  lcd_panel lcd_panel_i (.common_out_reg(common_out_reg), .segment_out_reg(segment_out_reg),
    .sel_com(sel_com), .lit(lit));

  // ----------------------------------------
  // access and compare tasks
  // ----------------------------------------
  task automatic conclude();
    $display("mismatches %0d, comparisons %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : conclude

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // op is {wr, rd, set, clear}; one idle cycle follows every request
  task automatic req(input logic [3:0] op, input logic [1:0] idx, input logic [6:0] a,
    input logic [3:0] d);
    @(posedge mclk);
    cpu_req <= {op, idx, a, d};
    @(posedge mclk);
    cpu_req <= '0;
    #1;
  endtask : req

  task automatic rd_chk(input string name, input logic [6:0] a, input logic [3:0] e);
    req(4'h4, 2'h0, a, 4'h0);
    chk(name, {28'h0, e}, {28'h0, rd_data_reg});
  endtask : rd_chk

  task automatic wr_ram(input int i, input logic [3:0] d);
    mem[i] = d;
    req(4'h8, 2'h0, `RAM_FIRST_ADDR + 7'(i), d);
  endtask : wr_ram

  // write then read the same word on consecutive edges, no idle gap
  task automatic wr_rd(input int i, input logic [3:0] d);
    mem[i] = d;
    @(posedge mclk);
    cpu_req <= {4'h8, 2'h0, `RAM_FIRST_ADDR + 7'(i), d};
    @(posedge mclk);
    cpu_req <= {4'h4, 2'h0, `RAM_FIRST_ADDR + 7'(i), 4'h0};
    @(posedge mclk);
    cpu_req <= '0;
    #1;
    chk("ram_back", {28'h0, d}, {28'h0, rd_data_reg});
  endtask : wr_rd

  // panel outputs trail a control write by two edges
  task automatic settle();
    repeat (3) @(posedge mclk);
    #1;
  endtask : settle

  task automatic wait_sel(input logic [1:0] p);
    int i;
    for (i = 0; i < 9000 && sel_com !== p; i++) begin
      @(posedge mclk);
      #1;
    end
    if (i == 9000) begin
      n_errors++;
      conclude();
    end
  endtask : wait_sel

  task automatic scan();
    logic [31:0] e;
    settle();
    for (int p = 0; p < 4; p++) begin
      wait_sel(2'(p));
      for (int s = 0; s < 32; s++) e[s] = mem[s][p];
      chk("lit", e, lit);
    end
  endtask : scan

  task automatic duty(input logic [1:0] d);
    int m = 0;
    req(4'h8, 2'h0, `DUTY_CLK_ADDR, {2'h0, d});
    settle();
    repeat (1200) begin
      @(posedge mclk);
      #1;
      if (int'(sel_com) > m) m = int'(sel_com);
    end
    chk("last_phase", 3 - d, m);
  endtask : duty

  task automatic period(input logic [1:0] c, input int e);
    int n;
    req(4'h8, 2'h0, `DUTY_CLK_ADDR, {c, 2'h0});
    wait_sel(2'h0);
    wait_sel(2'h1);
    for (n = 0; n < 2100 && sel_com === 2'h1; n++) begin
      @(posedge mclk);
      #1;
    end
    chk("period", e, n);
  endtask : period

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (9) @(posedge mclk);
    #1;
    chk("in_reset", 0, {|segment_out_reg, common_out_reg, power_switch_reg});
    @(posedge mclk);
    rst_n <= 1'b1;
    for (int i = 0; i < 32; i++) wr_ram(i, 4'(i + 3));
    rd_chk("ram_first", `RAM_FIRST_ADDR, mem[0]);
    rd_chk("ram_last", `RAM_LAST_ADDR, mem[31]);
    wr_rd(5, 4'h9);
    req(4'h8, 2'h0, 7'h70, 4'hF);
    rd_chk("unmapped", 7'h70, 4'h0);
    rd_chk("ctrl_wo", `DISP_CTRL_ADDR, 4'h0);
    chk("ctrl_reset", 0, {power_switch_reg, divider_connect_reg});
    for (int i = 0; i < 4; i++) req(4'h2, 2'(i), `DISP_CTRL_ADDR, 4'h0);
    req(4'h1, `BIT_POWER_SW, `DISP_CTRL_ADDR, 4'h0);
    settle();
    chk("bit_clear", 2'b01, {power_switch_reg, divider_connect_reg});
    req(4'h2, `BIT_POWER_SW, `DISP_CTRL_ADDR, 4'h0);
    settle();
    chk("switch_on", 1, power_switch_reg);
    req(4'h8, 2'h0, `DISP_CTRL_ADDR, 4'h5);
    settle();
    chk("ctrl_write", 0, {power_switch_reg, divider_connect_reg});
    req(4'h8, 2'h0, `DISP_CTRL_ADDR, 4'hF);
    req(4'h8, 2'h0, `DUTY_CLK_ADDR, 4'h0);
    scan();
    // with the enable low the scan must not step, though two phases pass
    @(posedge mclk);
    ce <= 1'b0;
    @(posedge mclk);
    #1;
    held_com = common_out_reg;
    repeat (300) @(posedge mclk);
    #1;
    chk("freeze", held_com, common_out_reg);
    @(posedge mclk);
    ce <= 1'b1;
    wr_ram(0, ~mem[0]);
    wr_ram(31, ~mem[31]);
    scan();
    req(4'h1, `BIT_DISPLAY_ON, `DISP_CTRL_ADDR, 4'h0);
    settle();
    chk("blank", 0, lit);
    req(4'h2, `BIT_DISPLAY_ON, `DISP_CTRL_ADDR, 4'h0);
    for (int d = 0; d < 4; d++) duty(2'(d));
    period(2'h0, 128);
    period(2'h1, 256);
    period(2'h2, 256);
    @(posedge mclk);
    timer_a_sub_select <= 1'b0;
    period(2'h3, 2048);
    @(posedge mclk);
    timer_a_sub_select <= 1'b1;
    period(2'h3, 512);
    @(posedge mclk);
    low_power_mode <= 1'b1;
    wait_sel(2'h0);
    wait_sel(2'h1);
    chk("lp_drive", 1, drive_active_reg);
    // system-derived source must stall the scan while in low power
    req(4'h8, 2'h0, `DUTY_CLK_ADDR, 4'h8);
    settle();
    held_com = common_out_reg;
    repeat (600) @(posedge mclk);
    #1;
    chk("lp_stall", held_com, common_out_reg);
    req(4'h1, `BIT_LP_DISPLAY, `DISP_CTRL_ADDR, 4'h0);
    settle();
    chk("lp_ground", 0, {|segment_out_reg, common_out_reg, power_switch_reg});
    @(posedge mclk);
    low_power_mode <= 1'b0;
    settle();
    chk("awake", 2'b11, {drive_active_reg, power_switch_reg});
    conclude();
  end
endmodule : tb_top
`default_nettype wire
